//--- logic/ccv_stream_port.sv
// Stream port and conversion pipeline of the color converter, fixed build.
`timescale 1ns/1ps
module ccv_stream_port (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic aclken_i,
  input wire logic [ccv_pkg::TDATA_W-1:0] s_axis_video_tdata_i,
  input wire logic s_axis_video_tvalid_i,
  output logic s_axis_video_tready_o,
  input wire logic s_axis_video_tuser_i,
  input wire logic s_axis_video_tlast_i,
  output logic [ccv_pkg::TDATA_W-1:0] m_axis_video_tdata_o,
  output logic m_axis_video_tvalid_o,
  input wire logic m_axis_video_tready_i,
  output logic m_axis_video_tuser_o,
  output logic m_axis_video_tlast_o
);

  // --------------------------------------------------------------------
  // State and local signals
  // --------------------------------------------------------------------
  // This build has no control bus and no interrupt pins; every setting
  // is fixed in the package and only reset and enable act at run time.
  // With no control bus there is no second clock domain to keep apart.

  typedef struct packed {
    ccv_pkg::ccv_stage_t [ccv_pkg::PIPE_STAGES-1:0] pipe;
  } ccv_port_state_t;

  localparam ccv_port_state_t PORT_RST = '0;

  ccv_port_state_t q;
  ccv_port_state_t d;
  logic advance;
  logic accept;
  ccv_pkg::ccv_stage_t last_stage;
  ccv_pkg::ccv_beat_t push_beat;

  ccv_buf_if bif ();

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------

  // Upper limit stage: values above full scale are cut to full scale.
  function automatic logic [ccv_pkg::CALC_W-1:0] ccv_upper(
    input logic [ccv_pkg::CALC_W-1:0] v
  );
    if ($signed(v) > $signed(ccv_pkg::CLIP_MAX))
    begin
      return ccv_pkg::CLIP_MAX;
    end
    return v;
  endfunction

  // Lower limit stage: negative results are raised to zero.
  function automatic logic [ccv_pkg::CALC_W-1:0] ccv_lower(
    input logic [ccv_pkg::CALC_W-1:0] v
  );
    if ($signed(v) < $signed(ccv_pkg::CLAMP_MIN))
    begin
      return ccv_pkg::CLAMP_MIN;
    end
    return v;
  endfunction

  // Widens one packed component to the signed working width.
  function automatic logic signed [ccv_pkg::CALC_W-1:0] ccv_widen(
    input logic [ccv_pkg::COMP_W-1:0] c
  );
    return $signed({{(ccv_pkg::CALC_W - ccv_pkg::COMP_W){1'b0}}, c});
  endfunction

  // Converts one input pixel with a shift-and-add matrix.
  function automatic ccv_pkg::ccv_stage_t ccv_convert(
    input logic [ccv_pkg::TDATA_W-1:0] px,
    input logic vld,
    input logic sof,
    input logic line_end_marker
  );
    logic signed [ccv_pkg::CALC_W-1:0] y;
    logic signed [ccv_pkg::CALC_W-1:0] cb;
    logic signed [ccv_pkg::CALC_W-1:0] cr;
    ccv_pkg::ccv_stage_t st;
    y = ccv_widen(px[ccv_pkg::Y_LSB +: ccv_pkg::COMP_W]);
    cb = ccv_widen(px[ccv_pkg::CB_LSB +: ccv_pkg::COMP_W])
      - $signed(ccv_pkg::CHROMA_MID);
    cr = ccv_widen(px[ccv_pkg::CR_LSB +: ccv_pkg::COMP_W])
      - $signed(ccv_pkg::CHROMA_MID);
    st.valid = vld;
    // Markers travel only with a real beat, never with a bubble.
    st.sof = vld & sof;
    st.line_end_marker = vld & line_end_marker;
    st.r = y + cr + (cr >>> 2) + (cr >>> 3);
    st.g = y - (cb >>> 2) - (cb >>> 3) - (cr >>> 1) - (cr >>> 3)
      - (cr >>> 4);
    st.b = y + cb + (cb >>> 1) + (cb >>> 2);
    return st;
  endfunction

  // --------------------------------------------------------------------
  // Handshake decisions
  // --------------------------------------------------------------------

  // The whole pipeline moves only on an enabled edge with buffer room,
  // so a stalled sink backs up into input ready and nothing is lost.
  assign advance = aclken_i & bif.in_ready;
  assign accept = advance & s_axis_video_tvalid_i;
  assign last_stage = q.pipe[ccv_pkg::PIPE_STAGES-1];

  // --------------------------------------------------------------------
  // Pipeline next state
  // --------------------------------------------------------------------

  // Shifts one stage per enabled edge with buffer room; limits apply at their own stages.
  always_comb
  begin
    d = q;
    if (advance)
    begin
      d.pipe[0] = ccv_convert(s_axis_video_tdata_i, accept,
        s_axis_video_tuser_i, s_axis_video_tlast_i);
      for (int i = 1; i < ccv_pkg::PIPE_STAGES; i++)
      begin
        d.pipe[i] = q.pipe[i-1];
        if (i == ccv_pkg::CLIP_STAGE)
        begin
          d.pipe[i].r = ccv_upper(q.pipe[i-1].r);
          d.pipe[i].g = ccv_upper(q.pipe[i-1].g);
          d.pipe[i].b = ccv_upper(q.pipe[i-1].b);
        end
        if (i == ccv_pkg::CLAMP_STAGE)
        begin
          d.pipe[i].r = ccv_lower(q.pipe[i-1].r);
          d.pipe[i].g = ccv_lower(q.pipe[i-1].g);
          d.pipe[i].b = ccv_lower(q.pipe[i-1].b);
        end
      end
    end
  end

  // Reset takes effect even while the clock enable is low.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q <= PORT_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Output packing and buffer
  // --------------------------------------------------------------------

  // Packs the limited components; the pad bits above stay zero.
  always_comb
  begin
    push_beat = ccv_pkg::BEAT_RST;
    push_beat.sof = last_stage.sof;
    push_beat.line_end_marker = last_stage.line_end_marker;
    push_beat.data[ccv_pkg::R_LSB +: ccv_pkg::COMP_W] =
      last_stage.r[ccv_pkg::COMP_W-1:0];
    push_beat.data[ccv_pkg::G_LSB +: ccv_pkg::COMP_W] =
      last_stage.g[ccv_pkg::COMP_W-1:0];
    push_beat.data[ccv_pkg::B_LSB +: ccv_pkg::COMP_W] =
      last_stage.b[ccv_pkg::COMP_W-1:0];
  end

  // The buffer sees the same enable, so its flags freeze with the core.
  assign bif.ce = aclken_i;
  assign bif.in_valid = last_stage.valid;
  assign bif.in_beat = push_beat;
  assign bif.out_ready = m_axis_video_tready_i;

  ccv_out_buf u_out_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .bif(bif.buf_side)
  );

  // Port outputs come from buffer flops and its fill count.
  assign s_axis_video_tready_o = bif.in_ready;
  assign m_axis_video_tvalid_o = bif.out_valid;
  assign m_axis_video_tdata_o = bif.out_beat.data;
  assign m_axis_video_tuser_o = bif.out_beat.sof;
  assign m_axis_video_tlast_o = bif.out_beat.line_end_marker;

endmodule

//--- logic/ccv_pkg.sv
// Shared constants and types for the color converter stream port.
package ccv_pkg;

  // --------------------------------------------------------------------
  // Pixel word layout
  // --------------------------------------------------------------------
  localparam int COMP_W = 10;
  localparam int TDATA_W = 32;
  localparam int PAD_W = TDATA_W - 3 * COMP_W;
  localparam int CALC_W = 13;
  localparam int Y_LSB = 0;
  localparam int CB_LSB = 10;
  localparam int CR_LSB = 20;
  localparam int G_LSB = 0;
  localparam int B_LSB = 10;
  localparam int R_LSB = 20;

  // --------------------------------------------------------------------
  // Latency and pipeline shape
  // --------------------------------------------------------------------
  localparam int LAT_BASE = 9;
  localparam int HAS_CLIP = 1;
  localparam int HAS_CLAMP = 1;
  localparam int LATENCY = LAT_BASE + HAS_CLIP + HAS_CLAMP;
  localparam int PIPE_STAGES = LATENCY;
  localparam int CLIP_STAGE = PIPE_STAGES - 2;
  localparam int CLAMP_STAGE = PIPE_STAGES - 1;
  localparam int RESET_MIN_CYCLES = 32;

  // --------------------------------------------------------------------
  // Conversion limits and offsets
  // --------------------------------------------------------------------
  localparam logic [CALC_W-1:0] CLIP_MAX = 13'h03FF;
  localparam logic [CALC_W-1:0] CLAMP_MIN = 13'h0000;
  localparam logic [CALC_W-1:0] CHROMA_MID = 13'h0200;

  // --------------------------------------------------------------------
  // Output buffer
  // --------------------------------------------------------------------
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic sof;
    logic line_end_marker;
    logic [TDATA_W-1:0] data;
  } ccv_beat_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic line_end_marker;
    logic [CALC_W-1:0] r;
    logic [CALC_W-1:0] g;
    logic [CALC_W-1:0] b;
  } ccv_stage_t;

  localparam ccv_stage_t STAGE_RST = '0;
  localparam ccv_beat_t BEAT_RST = '0;

endpackage

//--- logic/ccv_buf_if.sv
// Link between the conversion pipeline and its output buffer.
`timescale 1ns/1ps
interface ccv_buf_if;
  logic ce;
  logic in_valid;
  logic in_ready;
  ccv_pkg::ccv_beat_t in_beat;
  logic out_valid;
  logic out_ready;
  ccv_pkg::ccv_beat_t out_beat;

  modport buf_side (
    input ce,
    input in_valid,
    input in_beat,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_beat
  );

  modport user_side (
    output ce,
    output in_valid,
    output in_beat,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_beat
  );
endinterface

//--- logic/ccv_out_buf.sv
// Two-entry output buffer between the pipeline and the downstream sink.
`timescale 1ns/1ps
module ccv_out_buf (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  ccv_buf_if.buf_side bif
);

  typedef struct packed {
    ccv_pkg::ccv_beat_t [1:0] mem;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] cnt;
  } ccv_buf_state_t;

  localparam ccv_buf_state_t BUF_RST = '0;

  ccv_buf_state_t q;
  ccv_buf_state_t d;
  logic push;
  logic pop;

  // Push and pop only on enabled edges, so a frozen clock holds all.
  always_comb
  begin
    d = q;
    push = bif.ce & bif.in_valid & (q.cnt != ccv_pkg::BUF_FULL);
    pop = bif.ce & bif.out_ready & (q.cnt != ccv_pkg::BUF_EMPTY);
    if (push)
    begin
      d.mem[q.wr_idx] = bif.in_beat;
      d.wr_idx = ~q.wr_idx;
    end
    if (pop)
    begin
      d.rd_idx = ~q.rd_idx;
    end
    case ({push, pop})
      2'b10: d.cnt = q.cnt + 2'h1;
      2'b01: d.cnt = q.cnt - 2'h1;
      default: d.cnt = q.cnt;
    endcase
  end

  // Reset wins over the clock enable.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      q <= BUF_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Handshake flags come straight from the fill count.
  assign bif.in_ready = (q.cnt != ccv_pkg::BUF_FULL);
  assign bif.out_valid = (q.cnt != ccv_pkg::BUF_EMPTY);
  assign bif.out_beat = q.mem[q.rd_idx];

endmodule

//--- dv/ccv_sva.sv
// Concurrent checks on the ports of the color converter stream port.
`timescale 1ns/1ps
module ccv_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic aclken_i,
  input wire logic [ccv_pkg::TDATA_W-1:0] s_axis_video_tdata_i,
  input wire logic s_axis_video_tvalid_i,
  input wire logic s_axis_video_tready_o,
  input wire logic s_axis_video_tuser_i,
  input wire logic s_axis_video_tlast_i,
  input wire logic [ccv_pkg::TDATA_W-1:0] m_axis_video_tdata_o,
  input wire logic m_axis_video_tvalid_o,
  input wire logic m_axis_video_tready_i,
  input wire logic m_axis_video_tuser_o,
  input wire logic m_axis_video_tlast_o
);
  // ------------------------------------------------------------------
  // Port checks
  // ------------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // A low enable freezes every output; a waiting beat is held whole.
  hold_on_ce_a: assert property (
    !aclken_i |=> $stable({m_axis_video_tdata_o, m_axis_video_tvalid_o,
      m_axis_video_tuser_o, m_axis_video_tlast_o}))
    else $error("outputs moved while the enable was low");
  ready_ce_a: assert property (
    !aclken_i |=> $stable(s_axis_video_tready_o))
    else $error("input ready moved while the enable was low");
  out_hold_a: assert property (
    m_axis_video_tvalid_o && !m_axis_video_tready_i |=>
      m_axis_video_tvalid_o && $stable({m_axis_video_tdata_o,
      m_axis_video_tuser_o, m_axis_video_tlast_o}))
    else $error("output beat dropped or changed before it was taken");
  pad_zero_a: assert property (
    m_axis_video_tvalid_o |-> m_axis_video_tdata_o[31:30] == 2'h0)
    else $error("pad bits of the output word are not zero");
  rst_idle_a: assert property (
    disable iff (1'b0) rst_i |=>
      !m_axis_video_tvalid_o && s_axis_video_tready_o)
    else $error("reset did not clear the stream ports");
  full_only_a: assert property (
    !s_axis_video_tready_o |-> m_axis_video_tvalid_o)
    else $error("input ready low with no output beat waiting");
  ready_rise_a: assert property (
    $rose(s_axis_video_tready_o) |-> $past(rst_i) || $past(aclken_i
      && m_axis_video_tvalid_o && m_axis_video_tready_i))
    else $error("input ready rose without an output beat leaving");
  valid_fall_a: assert property (
    $fell(m_axis_video_tvalid_o) |->
      $past(m_axis_video_tready_i && aclken_i))
    else $error("output valid fell without a transfer");
  early_out_a: assert property (
    $fell(rst_i) |-> !m_axis_video_tvalid_o [*8])
    else $error("output beat appeared too soon after reset");
endmodule

bind ccv_stream_port ccv_sva chk_u (.sys_clk_i, .rst_i, .aclken_i,
  .s_axis_video_tdata_i, .s_axis_video_tvalid_i, .s_axis_video_tready_o,
  .s_axis_video_tuser_i, .s_axis_video_tlast_i, .m_axis_video_tdata_o,
  .m_axis_video_tvalid_o, .m_axis_video_tready_i, .m_axis_video_tuser_o,
  .m_axis_video_tlast_o);

//--- dv/ccv_sink_model.sv
// Downstream sink model that paces the output ready line.
`timescale 1ns/1ps
module ccv_sink_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  input wire logic valid_i,
  output logic ready_o
);
  // Mode 0 holds ready early, mode 1 answers a cycle after valid, 2 stalls.
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || mode_i == 2'h2)
      ready_o <= 1'b0;
    else if (mode_i == 2'h0)
      ready_o <= 1'b1;
    else
      ready_o <= valid_i && !ready_o;
  end
endmodule

//--- dv/testbench.sv
// Self-checking testbench for the color converter stream port.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [9:0] y;
    logic sof;
    logic line_end_marker;
  } ccv_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [31:0] s_d = 32'h0;
  logic [31:0] m_d;
  logic s_v = 1'b0;
  logic s_u = 1'b0;
  logic s_l = 1'b0;
  logic s_r, m_v, m_r, m_u, m_l;
  logic [1:0] mode = 2'h0;
  logic wig = 1'b0;
  logic off = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  logic [33:0] expq[$];
  logic [33:0] exp_beat;
  ccv_row_t rows[8] = '{'{10'h000, 1'h1, 1'h0}, '{10'h001, 1'h0, 1'h0},
    '{10'h3FF, 1'h0, 1'h0}, '{10'h155, 1'h0, 1'h1},
    '{10'h2AA, 1'h0, 1'h0}, '{10'h200, 1'h0, 1'h0},
    '{10'h0F0, 1'h0, 1'h0}, '{10'h10F, 1'h0, 1'h1}};

  ccv_stream_port dut_u (.sys_clk_i(clk), .rst_i(rst), .aclken_i(ce),
    .s_axis_video_tdata_i(s_d), .s_axis_video_tvalid_i(s_v),
    .s_axis_video_tready_o(s_r), .s_axis_video_tuser_i(s_u),
    .s_axis_video_tlast_i(s_l), .m_axis_video_tdata_o(m_d),
    .m_axis_video_tvalid_o(m_v), .m_axis_video_tready_i(m_r),
    .m_axis_video_tuser_o(m_u), .m_axis_video_tlast_o(m_l));
  ccv_sink_model sink_u (.sys_clk_i(clk), .rst_i(rst), .mode_i(mode),
    .valid_i(m_v), .ready_o(m_r));

  // -------------------------------------------------------------------
  // Clock, enable pattern and output monitor
  // -------------------------------------------------------------------
  initial forever #2 clk = ~clk;

  // The enable drops for a cycle in five while wig is set.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ce <= !(off || (wig && cyc % 5 == 2));
  end

  // Every taken output beat must match the oldest beat sent.
  always @(posedge clk)
    if (!rst && ce && m_v && m_r)
    begin
      exp_beat = expq.size() ? expq.pop_front() : 34'h3FFFFFFFF;
      chk("out beat", {m_u, m_l, m_d}, exp_beat);
    end

  task automatic chk(string what, logic [33:0] seen, logic [33:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("%0d compared, %0d mismatched", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic give_up();
    mismatches++;
    end_sim();
  endtask

  // Offers one pixel and holds it until the edge that takes it.
  task automatic send(ccv_row_t r);
    logic ok;
    int k;
    s_v <= 1'b1;
    s_d <= {2'h0, 10'h200, 10'h200, r.y};
    s_u <= r.sof;
    s_l <= r.line_end_marker;
    expq.push_back({r.sof, r.line_end_marker, 2'h0, r.y, r.y, r.y});
    k = 0;
    do
    begin
      #1 ok = s_r && ce;
      @(posedge clk);
      k++;
    end while (!ok && k < 300);
    if (!ok)
      give_up();
  endtask

  // Waits, bounded, until every sent beat has come out.
  task automatic drain();
    s_v <= 1'b0;
    for (n = 0; n < 500 && expq.size() > 0; n++)
      @(posedge clk);
    if (expq.size() > 0)
      give_up();
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial
  begin
    repeat (32) @(posedge clk);
    chk("reset idle", {m_v, s_r, m_d}, {2'h1, 32'h0});
    rst <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      wig <= (p == 1);
      mode <= (p == 1) ? 2'h1 : 2'h0;
      foreach (rows[i])
        send(rows[i]);
      drain();
      $display("rows pass %0d done", p);
    end
    wig <= 1'b0;
    mode <= 2'h0;
    send(rows[3]);
    s_v <= 1'b0;
    for (n = 0; n < 50; n++)
    begin
      #1 if (m_v)
        break;
      @(posedge clk);
    end
    @(posedge clk);
    chk("latency", 34'(n), 34'h00B);
    drain();
    $display("latency test done");
    mode <= 2'h2;
    for (int i = 0; i < 13; i++)
      send(rows[i % 8]);
    s_v <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ready when full", {32'h0, m_v, s_r}, 34'h2);
    mode <= 2'h0;
    drain();
    $display("stall test done");
    mode <= 2'h2;
    send(rows[0]);
    send(rows[1]);
    s_v <= 1'b0;
    repeat (14) @(posedge clk);
    off <= 1'b1;
    rst <= 1'b1;
    repeat (32) @(posedge clk);
    expq.delete();
    chk("reset with enable low", {m_v, s_r, m_d}, {2'h1, 32'h0});
    rst <= 1'b0;
    off <= 1'b0;
    mode <= 2'h0;
    repeat (2) @(posedge clk);
    $display("reset test done");
    end_sim();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge clk);
    give_up();
  end
endmodule
